// >>> bench/vfs_bus_master.sv
// model of the fifo bus master facing the slave port
// the bench calls its tasks; it launches just after rising bus clock edges
`timescale 1ns/1ns
module vfs_bus_master (
  input wire logic link_clk,
  input wire logic space_avail_n,
  input wire logic recv_ack_n,
  input wire logic [7:0] fifo_data_out,
  input wire logic [7:0] fifo_data_oe_n,
  output logic [31:0] fifo_data_in,
  output logic [3:0] byte_en_in,
  output logic wr_n
);
  logic [31:0] m_data = '1;
  logic m_drv = 1'b0;
  logic [7:0] last_mid = 8'h00;
  logic [7:0] mid;
  initial begin
    wr_n = 1'b1;
    byte_en_in = 4'hF;
  end
  // undriven mid lanes flip each cycle so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++)
      mid[i] = !fifo_data_oe_n[i] ? fifo_data_out[i] : m_drv ? m_data[8 + i] : ~last_mid[i];
  end
  always @(posedge link_clk) last_mid <= mid;
  assign fifo_data_in = {m_data[31:16], mid, m_data[7:0]};
  // idle: strobe high, own lanes and byte enables high
  task go_idle;
    wr_n <= 1'b1;
    m_data <= '1;
    byte_en_in <= 4'hF;
    m_drv <= 1'b0;
  endtask
  // one word, only after the space flag is seen low
  task send_single(input logic [31:0] w);
    int n;
    for (n = 0; n < 400 && space_avail_n !== 1'b0; n++) @(negedge link_clk);
    // never write without room, even when the wait ran out
    if (space_avail_n === 1'b0) begin
      @(posedge link_clk);
      wr_n <= 1'b0;
      m_data <= w;
      m_drv <= 1'b1;
      @(posedge link_clk);
      go_idle;
    end
  endtask
  // command then one data word; gives up if no ack comes
  task send_four(input logic [7:0] ch, input logic [31:0] w);
    int n;
    for (n = 0; n < 400 && (fifo_data_oe_n !== 8'h00 || fifo_data_out[0] !== 1'b0); n++)
      @(negedge link_clk);
    @(posedge link_clk);
    wr_n <= 1'b0;
    byte_en_in <= vfs_pkg::CMD_WRITE;
    m_data <= {24'hFFFFFF, ch};
    @(posedge link_clk);
    m_data <= w;
    m_drv <= 1'b1;
    byte_en_in <= 4'hF;
    for (n = 0; n < 6 && recv_ack_n !== 1'b0; n++) @(negedge link_clk);
    @(posedge link_clk);
    go_idle;
  endtask
endmodule

// >>> bench/vfs_port_assertions.sv
// pin-level checks for the fifo slave port
// bound into vfs_port, sees its ports only
`timescale 1ns/1ns
module vfs_port_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic bus_clk_out,
  input wire logic [31:0] fifo_data_in,
  input wire logic [7:0] fifo_data_out,
  input wire logic [7:0] fifo_data_oe_n,
  input wire logic [3:0] byte_en_in,
  input wire logic [3:0] byte_en_oe_n,
  input wire logic wr_n,
  input wire logic recv_ack_n
);
  logic cmd_ok;
  // well formed command seen at idle while the slot is free
  assign cmd_ok = fifo_data_oe_n == 8'h00 && !fifo_data_out[0] && !wr_n
    && byte_en_in == 4'h1 && fifo_data_in[7:0] inside {[8'h01:8'h04]};

  a_clk_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_clk_out == link_clk) else $error("bus clock not forwarded");
  a_be_hiz: assert property (@(posedge link_clk) disable iff (!aresetn)
    byte_en_oe_n == 4'hF) else $error("byte enables driven");
  a_oe_release: assert property (@(posedge link_clk) disable iff (!aresetn)
    !wr_n && fifo_data_oe_n == 8'h00 |=> fifo_data_oe_n == 8'hFF)
    else $error("status lanes kept after strobe");
  a_idle_status: assert property (@(posedge link_clk) disable iff (!aresetn)
    fifo_data_oe_n == 8'h00 |-> fifo_data_out[7:4] == 4'hF
    && fifo_data_out[3:0] inside {4'h0, 4'hF}) else $error("bad idle status");
  a_idle_no_ack: assert property (@(posedge link_clk) disable iff (!aresetn)
    fifo_data_oe_n == 8'h00 |-> recv_ack_n) else $error("ack while idle");
  a_cmd_ack: assert property (@(posedge link_clk) disable iff (!aresetn)
    cmd_ok |=> !recv_ack_n) else $error("no ack after command");
  a_bad_cmd: assert property (@(posedge link_clk) disable iff (!aresetn)
    fifo_data_oe_n == 8'h00 && !wr_n && !fifo_data_out[0] && !cmd_ok |=> recv_ack_n [*2])
    else $error("ack on bad command");
  a_take_ack: assert property (@(posedge link_clk) disable iff (!aresetn)
    !wr_n && !recv_ack_n |=> recv_ack_n) else $error("ack held after take");
endmodule

bind vfs_port vfs_port_assertions vfs_port_assertions_inst (.aclk(aclk), .aresetn(aresetn),
  .link_clk(link_clk), .bus_clk_out(bus_clk_out), .fifo_data_in(fifo_data_in),
  .fifo_data_out(fifo_data_out), .fifo_data_oe_n(fifo_data_oe_n), .byte_en_in(byte_en_in),
  .byte_en_oe_n(byte_en_oe_n), .wr_n(wr_n), .recv_ack_n(recv_ack_n));

// >>> bench/video_fifo_slave_bus_port_tb_top.sv
// self-checking bench for the fifo slave port
// drives axi4-lite and the chip pins; a master model sits on the fifo bus
`timescale 1ns/1ns
module video_fifo_slave_bus_port_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic lclk = 1'b0;
  logic rst_pin_n = 1'b1;
  logic int_n = 1'b1;
  logic [3:0] awa = 4'h0;
  logic [3:0] ara = 4'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic awr, wr, bv, arr, rv, clk_out, rate, wr_n, sa_n, ra_n;
  logic [1:0] br, rr;
  logic [31:0] rdt, fdi, d;
  logic [7:0] fdo, foe;
  logic [3:0] bei, beo, beoe;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  // clocks with unrelated phase
  always #50 aclk = ~aclk;
  always #24 lclk = ~lclk;

  vfs_port vfs_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .link_clk(lclk), .bus_clk_out(clk_out), .clk_rate_sel(rate), .fifo_data_in(fdi),
    .fifo_data_out(fdo), .fifo_data_oe_n(foe), .byte_en_in(bei), .byte_en_out(beo),
    .byte_en_oe_n(beoe), .wr_n(wr_n), .space_avail_n(sa_n), .recv_ack_n(ra_n),
    .reset_n(rst_pin_n), .int_n(int_n));
  vfs_bus_master vfs_bus_master_inst (.link_clk(lclk), .space_avail_n(sa_n),
    .recv_ack_n(ra_n), .fifo_data_out(fdo), .fifo_data_oe_n(foe), .fifo_data_in(fdi),
    .byte_en_in(bei), .wr_n(wr_n));

  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one write: address and data offered together, each dropped when taken
  task wrt(input logic [3:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wr) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge aclk); while (bv !== 1'b1);
    bry <= 1'b0;
  endtask
  task rdr(input logic [3:0] a, output logic [31:0] v);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rdt;
    rry <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    rdr(a, v);
    chk(v, e);
  endtask
  // poll until a received word is waiting
  task wait_valid;
    d = 32'h0;
    for (int i = 0; i < 40 && d[0] !== 1'b1; i++) rdr(vfs_pkg::REG_STAT, d);
  endtask

  // hang guard, well above the expected length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up;
    end
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(vfs_pkg::REG_CTRL, 32'h0);
    wrt(vfs_pkg::REG_CTRL, 32'h2);
    chk(32'(br), 32'(vfs_pkg::RESP_OKAY));
    repeat (2) @(posedge aclk);
    chk(32'(rate), 32'h1);
    // single channel: one word, flag high until software drains it
    wrt(vfs_pkg::REG_CTRL, 32'h4);
    vfs_bus_master_inst.send_single(32'hA5C31E0F);
    @(negedge lclk);
    chk(32'(sa_n), 32'h1);
    wait_valid;
    rd_chk(vfs_pkg::REG_CHAN, 32'h0);
    rd_chk(vfs_pkg::REG_DATA, 32'hA5C31E0F);
    wrt(vfs_pkg::REG_STAT, 32'hFFFFFFFF);
    chk(32'(br), 32'(vfs_pkg::RESP_OKAY));
    repeat (4) @(posedge aclk);
    rd_chk(vfs_pkg::REG_STAT, 32'h0);
    @(negedge lclk);
    chk(32'(sa_n), 32'h0);
    int_n <= 1'b0;
    repeat (6) @(posedge aclk);
    rd_chk(vfs_pkg::REG_STAT, 32'h2);
    int_n <= 1'b1;
    // four channel: idle status, a bad channel, then every channel
    wrt(vfs_pkg::REG_CTRL, 32'h5);
    repeat (4) @(posedge aclk);
    @(negedge lclk);
    chk(32'(foe), 32'(vfs_pkg::DOE_ON));
    chk(32'(fdo), 32'hF0);
    chk(32'(sa_n), 32'h0);
    vfs_bus_master_inst.send_four(8'h05, 32'h0);
    repeat (6) @(posedge aclk);
    rd_chk(vfs_pkg::REG_STAT, 32'h0);
    for (int c = 1; c <= 4; c++) begin
      vfs_bus_master_inst.send_four(8'(c), 32'h5A000000 + 32'(c));
      wait_valid;
      rd_chk(vfs_pkg::REG_CHAN, 32'(c));
      rd_chk(vfs_pkg::REG_DATA, 32'h5A000000 + 32'(c));
    end
    // chip reset pin clears the control register
    rst_pin_n <= 1'b0;
    repeat (6) @(posedge aclk);
    rst_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_chk(vfs_pkg::REG_CTRL, 32'h0);
    // misaligned address, outside the map
    wrt(4'h2, 32'h1);
    chk(32'(br), 32'(vfs_pkg::RESP_SLVERR));
    rdr(4'h2, d);
    chk(32'(rr), 32'(vfs_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    // byte enable pins: output value and enable both held off
    chk(32'({beo, beoe}), 32'hFF);
    wrap_up;
  end
endmodule

// >>> inc/vfs_pkg.sv
// constants and types for the video fifo slave bus port
// assumes a 32-bit axi4-lite register bus and a 32-bit fifo bus
package vfs_pkg;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_CHAN = 4'hC;
  // control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RATE_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  localparam logic CTRL_MODE_RST = 1'h0;
  localparam logic CTRL_RATE_RST = 1'h0;
  localparam logic CTRL_EN_RST = 1'h0;
  // status fields
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_INT_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  // bus clock rates selectable by the rate bit
  localparam int RATE_LOW_MHZ = 66;
  localparam int RATE_HIGH_MHZ = 100;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // four-channel command phase
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [7:0] CHAN_MIN = 8'h01;
  localparam logic [7:0] CHAN_MAX = 8'h04;
  localparam int NUM_CHAN = 4;
  localparam logic [3:0] IDLE_HI_NIB = 4'hF;
  localparam logic [7:0] DOE_OFF = 8'hFF;
  localparam logic [7:0] DOE_ON = 8'h00;
  localparam logic [3:0] BE_OE_OFF = 4'hF;
  localparam logic [2:0] CHAN_NONE = 3'h0;
  // link side states
  typedef enum logic [2:0] {
    LNK_IDLE = 3'b001,
    LNK_DATA = 3'b010,
    LNK_SKIP = 3'b100
  } vfs_lnk_e;
endpackage

// >>> src/vfs_port.sv
// slave side of a 32-bit synchronous fifo bus with axi4-lite registers
// assumes link_clk is the bus clock from the clock generator, unrelated
// to aclk, and that the master launches and samples on its rising edge
//
// Behaviour
// - bus clock is driven out to the master, rate 66 or 100 MHz selectable
// - data lines 0-7 and 16-31 are inputs only, never driven
// - data lines 8-15 are bidirectional, driven at four-channel idle, sampled otherwise
// - four byte-enable lines exist as bidirectional pins
// - single-channel: space flag low only while a word can be accepted
// - four-channel: space flag becomes optional idle status valid
// - four-channel: receive flag acts as data receive acknowledge
// - single-channel: write strobe qualifies each data word
// - four-channel: write strobe requests start of a transaction
// - write strobe is active low
// - logic held in reset while chip reset pin is low
// - low level on interrupt pin is an asserted request
// - first strobe cycle is command, data follows the acknowledge
// - command is write code plus channel 1-4; other channels ignored
// - at four-channel idle data 15:8 carry status; 11:8 are per-channel space, low
`timescale 1ns/1ns
module vfs_port #(
  parameter int AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  output logic bus_clk_out,
  output logic clk_rate_sel,
  input wire logic [31:0] fifo_data_in,
  output logic [7:0] fifo_data_out,
  output logic [7:0] fifo_data_oe_n,
  input wire logic [3:0] byte_en_in,
  output logic [3:0] byte_en_out,
  output logic [3:0] byte_en_oe_n,
  input wire logic wr_n,
  output logic space_avail_n,
  output logic recv_ack_n,
  input wire logic reset_n,
  input wire logic int_n
);
  // aclk domain state
  typedef struct packed {
    logic aw_have;
    logic [AW-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic mode;
    logic rate;
    logic en;
    logic rx_valid;
    logic [31:0] rx_word;
    logic [2:0] rx_chan;
    logic req_seen;
    logic ack_tgl;
  } vfs_sys_s;

  // link_clk domain state
  typedef struct packed {
    vfs_pkg::vfs_lnk_e st;
    logic full;
    logic [31:0] word;
    logic [2:0] chan;
    logic [2:0] cur_chan;
    logic req_tgl;
    logic ack_seen;
    logic sa_n;
    logic ack_n;
    logic [7:0] dout;
    logic [7:0] doe_n;
  } vfs_lnk_s;

  vfs_sys_s sys_q;
  vfs_sys_s sys_d;
  vfs_lnk_s lnk_q;
  vfs_lnk_s lnk_d;

  logic [1:0] pins_sync;
  logic chip_rst_n;
  logic int_req;
  logic sys_rst_n;
  logic lnk_rst_n;
  logic req_sync;
  logic ack_sync;
  logic [1:0] ctrl_sync;
  logic lnk_mode;
  logic lnk_en;

  // chip reset and interrupt pins are asynchronous to aclk
  vfs_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({reset_n, int_n}),
    .q(pins_sync)
  );

  assign chip_rst_n = pins_sync[1];
  assign int_req = ~pins_sync[0]; // low pin means request
  assign sys_rst_n = aresetn & chip_rst_n; // either reset holds the logic

  // reset into the link domain; this chain has no reset of its own
  vfs_sync #(.W(1), .RST_VAL(1'h0)) u_rst_sync (
    .clk(link_clk),
    .rst_n(1'b1),
    .d(sys_rst_n),
    .q(lnk_rst_n)
  );

  // handshake toggle from link to aclk
  vfs_sync #(.W(1), .RST_VAL(1'h0)) u_req_sync (
    .clk(aclk),
    .rst_n(sys_rst_n),
    .d(lnk_q.req_tgl),
    .q(req_sync)
  );

  // handshake toggle and control levels from aclk to link
  vfs_sync #(.W(1), .RST_VAL(1'h0)) u_ack_sync (
    .clk(link_clk),
    .rst_n(lnk_rst_n),
    .d(sys_q.ack_tgl),
    .q(ack_sync)
  );

  vfs_sync #(.W(2), .RST_VAL(2'h0)) u_ctrl_sync (
    .clk(link_clk),
    .rst_n(lnk_rst_n),
    .d({sys_q.mode, sys_q.en}),
    .q(ctrl_sync)
  );

  assign lnk_mode = ctrl_sync[1];
  assign lnk_en = ctrl_sync[0];

  // register side: axi4-lite slave and the receive holding word
  always_comb begin
    sys_d = sys_q;
    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      sys_d.aw_have = 1'b1;
      sys_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      sys_d.w_have = 1'b1;
      sys_d.wdata = s_axi_wdata;
      sys_d.wstrb0 = s_axi_wstrb[0];
    end
    if (sys_q.bvalid && s_axi_bready) begin
      sys_d.bvalid = 1'b0;
    end
    if (sys_q.aw_have && sys_q.w_have && !sys_q.bvalid) begin
      sys_d.aw_have = 1'b0;
      sys_d.w_have = 1'b0;
      sys_d.bvalid = 1'b1;
      sys_d.bresp = vfs_pkg::RESP_OKAY;
      unique case (sys_q.awaddr)
        vfs_pkg::REG_CTRL: begin
          // fields live in lane 0 only
          if (sys_q.wstrb0) begin
            sys_d.mode = sys_q.wdata[vfs_pkg::CTRL_MODE_BIT];
            sys_d.rate = sys_q.wdata[vfs_pkg::CTRL_RATE_BIT];
            sys_d.en = sys_q.wdata[vfs_pkg::CTRL_EN_BIT];
          end
        end
        vfs_pkg::REG_STAT, vfs_pkg::REG_DATA, vfs_pkg::REG_CHAN: begin
          sys_d.bresp = vfs_pkg::RESP_OKAY; // read-only, write dropped
        end
        default: begin
          sys_d.bresp = vfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // read response
    if (sys_q.rvalid && s_axi_rready) begin
      sys_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      sys_d.rvalid = 1'b1;
      sys_d.rresp = vfs_pkg::RESP_OKAY;
      sys_d.rdata = '0;
      unique case (s_axi_araddr)
        vfs_pkg::REG_CTRL: begin
          sys_d.rdata[vfs_pkg::CTRL_MODE_BIT] = sys_q.mode;
          sys_d.rdata[vfs_pkg::CTRL_RATE_BIT] = sys_q.rate;
          sys_d.rdata[vfs_pkg::CTRL_EN_BIT] = sys_q.en;
        end
        vfs_pkg::REG_STAT: begin
          sys_d.rdata[vfs_pkg::STAT_VALID_BIT] = sys_q.rx_valid;
          sys_d.rdata[vfs_pkg::STAT_INT_BIT] = int_req;
          sys_d.rdata[vfs_pkg::STAT_FULL_BIT] = sys_q.req_seen ^ sys_q.ack_tgl;
        end
        vfs_pkg::REG_DATA: begin
          sys_d.rdata = sys_q.rx_word;
          // reading the word frees the holding slot on the link side
          if (sys_q.rx_valid) begin
            sys_d.rx_valid = 1'b0;
            sys_d.ack_tgl = ~sys_q.ack_tgl;
          end
        end
        vfs_pkg::REG_CHAN: begin
          sys_d.rdata[2:0] = sys_q.rx_chan;
        end
        default: begin
          sys_d.rresp = vfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // the link word is stable while its toggle is unanswered
    if (req_sync != sys_q.req_seen) begin
      sys_d.req_seen = req_sync;
      sys_d.rx_valid = 1'b1;
      sys_d.rx_word = lnk_q.word;
      sys_d.rx_chan = lnk_q.chan;
    end
  end

  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      sys_q <= '{
        aw_have: 1'b0, awaddr: '0, w_have: 1'b0, wdata: 32'h0, wstrb0: 1'b0,
        bvalid: 1'b0, bresp: vfs_pkg::RESP_OKAY, rvalid: 1'b0, rresp: vfs_pkg::RESP_OKAY,
        rdata: 32'h0, mode: vfs_pkg::CTRL_MODE_RST, rate: vfs_pkg::CTRL_RATE_RST,
        en: vfs_pkg::CTRL_EN_RST, rx_valid: 1'b0, rx_word: 32'h0,
        rx_chan: vfs_pkg::CHAN_NONE, req_seen: 1'b0, ack_tgl: 1'b0
      };
    end else begin
      sys_q <= sys_d;
    end
  end

  // one write and one read in flight at a time
  assign s_axi_awready = !sys_q.aw_have && !sys_q.bvalid;
  assign s_axi_wready = !sys_q.w_have && !sys_q.bvalid;
  assign s_axi_bvalid = sys_q.bvalid;
  assign s_axi_bresp = sys_q.bresp;
  assign s_axi_arready = !sys_q.rvalid;
  assign s_axi_rvalid = sys_q.rvalid;
  assign s_axi_rdata = sys_q.rdata;
  assign s_axi_rresp = sys_q.rresp;

  // link side: everything sampled and launched on the bus clock rise
  always_comb begin
    logic strobe;
    logic take;
    logic cmd_ok;
    strobe = !wr_n; // only the low level counts
    take = 1'b0;
    cmd_ok = (byte_en_in == vfs_pkg::CMD_WRITE) &&
             (fifo_data_in[7:0] >= vfs_pkg::CHAN_MIN) &&
             (fifo_data_in[7:0] <= vfs_pkg::CHAN_MAX);
    lnk_d = lnk_q;
    // slot freed once the aclk side has read the word
    if (ack_sync != lnk_q.ack_seen) begin
      lnk_d.ack_seen = ack_sync;
      lnk_d.full = 1'b0;
    end
    unique case (lnk_q.st)
      vfs_pkg::LNK_IDLE: begin
        if (!lnk_mode) begin
          // strobe is the write enable; flag low means room
          take = strobe && lnk_en && !lnk_q.sa_n;
        end else if (strobe && lnk_en) begin
          // strobe cycle carries the command
          if (cmd_ok) begin // unknown channels fall through
            lnk_d.cur_chan = fifo_data_in[2:0];
            lnk_d.st = vfs_pkg::LNK_DATA;
          end else begin
            lnk_d.st = vfs_pkg::LNK_SKIP;
          end
        end
      end
      vfs_pkg::LNK_DATA: begin
        if (!strobe) begin
          lnk_d.st = vfs_pkg::LNK_IDLE;
        end else begin
          // a word counts only while the acknowledge is shown
          take = !lnk_q.ack_n;
        end
      end
      vfs_pkg::LNK_SKIP: begin
        if (!strobe) begin
          lnk_d.st = vfs_pkg::LNK_IDLE;
        end
      end
      default: begin
        lnk_d.st = vfs_pkg::LNK_IDLE;
      end
    endcase
    if (take && !lnk_q.full) begin
      lnk_d.full = 1'b1;
      lnk_d.word = fifo_data_in;
      lnk_d.chan = lnk_mode ? lnk_q.cur_chan : vfs_pkg::CHAN_NONE;
      lnk_d.req_tgl = ~lnk_q.req_tgl;
    end
    if (!lnk_mode) begin
      // low only while the slot can take a word
      lnk_d.sa_n = lnk_d.full || !lnk_en;
      lnk_d.ack_n = 1'b1; // held high in single-channel mode
      lnk_d.doe_n = vfs_pkg::DOE_OFF;
    end else begin
      // status valid only while idle status is really driven
      lnk_d.sa_n = !(lnk_d.st == vfs_pkg::LNK_IDLE && lnk_en);
      // acknowledge towards the master
      lnk_d.ack_n = !((lnk_d.st == vfs_pkg::LNK_DATA) && !lnk_d.full);
      // drive status on 15:8 only at idle; turn-around otherwise
      lnk_d.doe_n = (lnk_d.st == vfs_pkg::LNK_IDLE && lnk_en) ?
                    vfs_pkg::DOE_ON : vfs_pkg::DOE_OFF;
    end
    // one shared slot serves all channels, so every space bit matches
    lnk_d.dout = {vfs_pkg::IDLE_HI_NIB, {vfs_pkg::NUM_CHAN{lnk_d.full}}};
  end

  always_ff @(posedge link_clk) begin
    if (!lnk_rst_n) begin
      lnk_q <= '{
        st: vfs_pkg::LNK_IDLE, full: 1'b0, word: 32'h0, chan: vfs_pkg::CHAN_NONE,
        cur_chan: vfs_pkg::CHAN_NONE, req_tgl: 1'b0, ack_seen: 1'b0, sa_n: 1'b1,
        ack_n: 1'b1, dout: 8'hFF, doe_n: vfs_pkg::DOE_OFF
      };
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // bus clock forwarded from the generator clock
  assign bus_clk_out = link_clk;
  assign clk_rate_sel = sys_q.rate; // 0 selects 66 MHz, 1 selects 100 MHz
  assign space_avail_n = lnk_q.sa_n;
  assign recv_ack_n = lnk_q.ack_n;
  assign fifo_data_out = lnk_q.dout;
  assign fifo_data_oe_n = lnk_q.doe_n;
  // 31:16 and 7:0 have no output at all; only the idle status lines drive
  // byte enables are pins with a driver that this block keeps off
  assign byte_en_out = vfs_pkg::BE_OE_OFF;
  assign byte_en_oe_n = vfs_pkg::BE_OE_OFF;
endmodule

// >>> src/vfs_sync.sv
// three-stage synchroniser for levels and toggles
// assumes the input is quasi-static or changes at most once per few clocks
`timescale 1ns/1ns
module vfs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } vfs_sync_s;

  vfs_sync_s st_q;
  vfs_sync_s st_d;

  // a bit moves only once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;
endmodule
